// ---- ahs_consts.vh ----
// Purpose: constants for the axis homing sequencer
// Assumes: included by ahs_sequencer.v, the checker and the bench
// Notes:   modes 12..14 use the index pulse, 17..22 switches only
`ifndef AHS_CONSTS_VH
`define AHS_CONSTS_VH

// ==========================================================
// homing modes
`define AHS_MODE_W        5
`define AHS_MODE_12       5'h0c
`define AHS_MODE_13       5'h0d
`define AHS_MODE_14       5'h0e
`define AHS_MODE_15       5'h0f
`define AHS_MODE_16       5'h10
`define AHS_MODE_17       5'h11
`define AHS_MODE_18       5'h12
`define AHS_MODE_19       5'h13
`define AHS_MODE_20       5'h14
`define AHS_MODE_21       5'h15
`define AHS_MODE_22       5'h16

// ==========================================================
// exit events of a step
`define AHS_EV_HOME_ON    3'h0
`define AHS_EV_HOME_OFF   3'h1
`define AHS_EV_NLIM_ON    3'h2
`define AHS_EV_NLIM_OFF   3'h3
`define AHS_EV_PLIM_ON    3'h4
`define AHS_EV_PLIM_OFF   3'h5
`define AHS_EV_INDEX      3'h6
`define AHS_EV_NONE       3'h7

// ==========================================================
// step word fields
`define AHS_STEP_W        7
`define AHS_STEP_VALID    6
`define AHS_STEP_LAST     5
`define AHS_STEP_DIR      4
`define AHS_STEP_SPEED    3
`define AHS_STEP_EV_HI    2
`define AHS_STEP_EV_LO    0

// ==========================================================
// starting paths
`define AHS_PATH_OFF      2'h0
`define AHS_PATH_ON       2'h1
`define AHS_PATH_LIMIT    2'h2

// ==========================================================
// reset values
`define AHS_PHASE_RST     2'h0
`define AHS_PATH_RST      2'h0

`endif

// ---- ahs_sequencer.v ----
// Purpose: homing sequencer for one axis, modes 12..14 and 17..22
// Assumes: all inputs synchronous to clk, switches active high
// Notes:   direction 1 is positive, speed 1 is second-phase speed
`timescale 1ns/10ps
`include "ahs_consts.vh"

module ahs_sequencer (
	// clock and reset
	input  wire                   clk,
	input  wire                   resetn,
	// command
	input  wire                   homing_command,
	input  wire [`AHS_MODE_W-1:0] homing_mode,
	// axis sensors
	input  wire                   home_sw,
	input  wire                   lim_pos,
	input  wire                   lim_neg,
	input  wire                   index_pulse,
	// motion demand
	output reg                    move_en,
	output reg                    move_dir_pos,
	output reg                    move_speed_hi,
	// status
	output reg                    busy,
	output reg                    home_latch,
	output reg                    done,
	output reg                    mode_error
);

	// ==========================================================
	// states
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_STOP = 2'h2;

	// ==========================================================
	// step table: valid, last, dir, speed, exit event
	function [`AHS_STEP_W-1:0] ahs_step;
		input [`AHS_MODE_W-1:0] mode;
		input [1:0]             path;
		input [1:0]             phase;
		reg   [4:0]             sel;
		begin
			sel = {path, phase, 1'b0};
			ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
			case (mode)
			`AHS_MODE_12: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b0, 1'b0, `AHS_EV_HOME_ON};
				4'h1: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_INDEX};
				4'h4: ahs_step = {1'b1, 1'b0, 1'b1, 1'b1, `AHS_EV_HOME_OFF};
				4'h5: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_INDEX};
				4'h8: ahs_step = {1'b1, 1'b0, 1'b1, 1'b0, `AHS_EV_HOME_ON};
				4'h9: ahs_step = {1'b1, 1'b0, 1'b1, 1'b0, `AHS_EV_HOME_OFF};
				4'ha: ahs_step = {1'b1, 1'b0, 1'b0, 1'b0, `AHS_EV_HOME_ON};
				4'hb: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_INDEX};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_13: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b0, 1'b0, `AHS_EV_HOME_ON};
				4'h1: ahs_step = {1'b1, 1'b0, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'h2: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_INDEX};
				4'h4: ahs_step = {1'b1, 1'b0, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'h5: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_INDEX};
				4'h8: ahs_step = {1'b1, 1'b0, 1'b1, 1'b0, `AHS_EV_HOME_ON};
				4'h9: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_INDEX};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_14: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b0, 1'b0, `AHS_EV_HOME_ON};
				4'h1: ahs_step = {1'b1, 1'b0, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'h2: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_INDEX};
				4'h4: ahs_step = {1'b1, 1'b0, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'h5: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_INDEX};
				4'h8: ahs_step = {1'b1, 1'b0, 1'b1, 1'b0, `AHS_EV_HOME_ON};
				4'h9: ahs_step = {1'b1, 1'b0, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'ha: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_INDEX};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_17: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b0, 1'b0, `AHS_EV_NLIM_ON};
				4'h1: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_NLIM_OFF};
				4'h4: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_NLIM_OFF};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_18: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b1, 1'b0, `AHS_EV_PLIM_ON};
				4'h1: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_PLIM_OFF};
				4'h4: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_PLIM_OFF};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_19: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b1, 1'b0, `AHS_EV_HOME_ON};
				4'h1: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'h4: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_20: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b1, 1'b1, 1'b0, `AHS_EV_HOME_ON};
				4'h4: ahs_step = {1'b1, 1'b0, 1'b0, 1'b1, `AHS_EV_HOME_OFF};
				4'h5: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_HOME_ON};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_21: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b0, 1'b0, 1'b0, `AHS_EV_HOME_ON};
				4'h1: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_HOME_OFF};
				4'h4: ahs_step = {1'b1, 1'b1, 1'b1, 1'b1, `AHS_EV_HOME_OFF};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			`AHS_MODE_22: begin
				case (sel[4:1])
				4'h0: ahs_step = {1'b1, 1'b1, 1'b0, 1'b0, `AHS_EV_HOME_ON};
				4'h4: ahs_step = {1'b1, 1'b0, 1'b1, 1'b1, `AHS_EV_HOME_OFF};
				4'h5: ahs_step = {1'b1, 1'b1, 1'b0, 1'b1, `AHS_EV_HOME_ON};
				default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
				endcase
			end
			default: ahs_step = {1'b0, 1'b0, 1'b0, 1'b0, `AHS_EV_NONE};
			endcase
		end
	endfunction

	// ==========================================================
	// modes that fall back on the limit-reversal path
	function ahs_has_limit_path;
		input [`AHS_MODE_W-1:0] mode;
		begin
			case (mode)
			`AHS_MODE_12: ahs_has_limit_path = 1'b1;
			`AHS_MODE_13: ahs_has_limit_path = 1'b1;
			`AHS_MODE_14: ahs_has_limit_path = 1'b1;
			default:      ahs_has_limit_path = 1'b0;
			endcase
		end
	endfunction

	// ==========================================================
	// edge detection of the four sensors
	wire [3:0] sens_now;
	wire [3:0] sens_rise;
	wire [3:0] sens_fall;

	assign sens_now = {index_pulse, lim_pos, lim_neg, home_sw};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
			// one history flop per sensor, single driver each
			reg prev_reg;
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					prev_reg <= 1'b0;
				end else begin
					prev_reg <= sens_now[gi];
				end
			end
			assign sens_rise[gi] = sens_now[gi] & ~prev_reg;
			assign sens_fall[gi] = ~sens_now[gi] & prev_reg;
		end
	endgenerate

	// ==========================================================
	// sequencer registers
	reg [1:0]             state_reg;
	reg [1:0]             state_next;
	reg [`AHS_MODE_W-1:0] mode_reg;
	reg [1:0]             path_reg;
	reg [1:0]             path_next;
	reg [1:0]             phase_reg;
	reg [1:0]             phase_next;

	wire [`AHS_STEP_W-1:0] cur_step;
	wire [`AHS_STEP_W-1:0] start_step;
	wire [`AHS_STEP_W-1:0] nxt_step;
	wire [2:0]             cur_ev;
	wire [1:0]             start_path;
	reg                    ev_hit;
	reg                    limit_hit;

	assign cur_step = ahs_step(mode_reg, path_reg, phase_reg);
	assign cur_ev   = cur_step[`AHS_STEP_EV_HI:`AHS_STEP_EV_LO];

	// starting case from the switch that the mode watches
	assign start_path = (homing_mode == `AHS_MODE_17) ?
	                    (lim_neg ? `AHS_PATH_ON : `AHS_PATH_OFF) :
	                    (homing_mode == `AHS_MODE_18) ?
	                    (lim_pos ? `AHS_PATH_ON : `AHS_PATH_OFF) :
	                    (home_sw ? `AHS_PATH_ON : `AHS_PATH_OFF);
	assign start_step = ahs_step(homing_mode, start_path, `AHS_PHASE_RST);
	// step that the run enters at the coming edge
	assign nxt_step   = ahs_step(mode_reg, path_next, phase_next);

	// ==========================================================
	// exit event of the active step
	always @* begin
		case (cur_ev)
		`AHS_EV_HOME_ON:  ev_hit = sens_rise[0];
		`AHS_EV_HOME_OFF: ev_hit = sens_fall[0];
		`AHS_EV_NLIM_ON:  ev_hit = sens_rise[1];
		`AHS_EV_NLIM_OFF: ev_hit = sens_fall[1];
		`AHS_EV_PLIM_ON:  ev_hit = sens_rise[2];
		`AHS_EV_PLIM_OFF: ev_hit = sens_fall[2];
		`AHS_EV_INDEX:    ev_hit = sens_rise[3];
		default:          ev_hit = 1'b0;
		endcase
		limit_hit = ahs_has_limit_path(mode_reg) & (path_reg == `AHS_PATH_OFF) &
		            (phase_reg == `AHS_PHASE_RST) & sens_rise[1] & ~home_sw;
	end

	// ==========================================================
	// next-state logic
	always @* begin
		state_next = state_reg;
		path_next  = path_reg;
		phase_next = phase_reg;
		case (state_reg)
		ST_IDLE: begin
			if (homing_command && start_step[`AHS_STEP_VALID]) begin
				state_next = ST_RUN;
				path_next  = start_path;
				phase_next = `AHS_PHASE_RST;
			end
		end
		ST_RUN: begin
			if (limit_hit) begin
				path_next  = `AHS_PATH_LIMIT;
				phase_next = `AHS_PHASE_RST;
			end else if (ev_hit && cur_step[`AHS_STEP_LAST]) begin
				state_next = ST_STOP;
			end else if (ev_hit) begin
				phase_next = phase_reg + 2'h1;
			end
		end
		ST_STOP: begin
			state_next = ST_IDLE;
			path_next  = `AHS_PATH_RST;
			phase_next = `AHS_PHASE_RST;
		end
		default: begin
			state_next = ST_IDLE;
			path_next  = `AHS_PATH_RST;
			phase_next = `AHS_PHASE_RST;
		end
		endcase
	end

	// ==========================================================
	// state and outputs
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= ST_IDLE;
			mode_reg      <= {`AHS_MODE_W{1'b0}};
			path_reg      <= `AHS_PATH_RST;
			phase_reg     <= `AHS_PHASE_RST;
			move_en       <= 1'b0;
			move_dir_pos  <= 1'b0;
			move_speed_hi <= 1'b0;
			busy          <= 1'b0;
			home_latch    <= 1'b0;
			done          <= 1'b0;
			mode_error    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			path_reg   <= path_next;
			phase_reg  <= phase_next;
			home_latch <= 1'b0;
			done       <= 1'b0;
			mode_error <= 1'b0;
			if (state_reg == ST_IDLE && homing_command) begin
				mode_reg   <= homing_mode;
				mode_error <= ~start_step[`AHS_STEP_VALID];
			end
			if (state_reg == ST_RUN && ev_hit && cur_step[`AHS_STEP_LAST] && !limit_hit) begin
				home_latch <= 1'b1;
				done       <= 1'b1;
			end
			busy <= (state_next == ST_RUN);
			if (state_next == ST_RUN) begin
				move_en <= 1'b1;
				if (state_reg == ST_IDLE) begin
					move_dir_pos  <= start_step[`AHS_STEP_DIR];
					move_speed_hi <= start_step[`AHS_STEP_SPEED];
				end else begin
					move_dir_pos  <= nxt_step[`AHS_STEP_DIR];
					move_speed_hi <= nxt_step[`AHS_STEP_SPEED];
				end
			end else begin
				move_en       <= 1'b0;
				move_dir_pos  <= 1'b0;
				move_speed_hi <= 1'b0;
			end
		end
	end

endmodule

// ---- ahs_checker_properties.sv ----
// Purpose: port checker for ahs_sequencer
// Assumes: bound to every ahs_sequencer instance
// Notes:   mode of the running sequence kept in helper logic
`timescale 1ns/10ps
`include "ahs_consts.vh"

module ahs_checker (
	// clock and reset
	input wire                   clk,
	input wire                   resetn,
	// command and sensors
	input wire                   homing_command,
	input wire [`AHS_MODE_W-1:0] homing_mode,
	input wire                   home_sw,
	input wire                   lim_pos,
	input wire                   lim_neg,
	input wire                   index_pulse,
	// motion and status
	input wire                   move_en,
	input wire                   move_dir_pos,
	input wire                   move_speed_hi,
	input wire                   busy,
	input wire                   home_latch,
	input wire                   done,
	input wire                   mode_error
);
	reg  [`AHS_MODE_W-1:0] mode_reg;
	wire                   take;
	wire                   good;
	assign take = homing_command && !busy && !done;
	assign good = homing_mode >= `AHS_MODE_12 && homing_mode <= `AHS_MODE_22
		&& homing_mode != `AHS_MODE_15 && homing_mode != `AHS_MODE_16;
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			mode_reg <= 5'h00;
		else if (take)
			mode_reg <= homing_mode;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// ==========================================================
	// assertions
	a_start_run: assert property (
		take && good |=> busy && move_en) else $error("run not started");
	a_bad_mode: assert property (
		take && !good |=> !busy ##[0:1] mode_error) else $error("bad mode not refused");
	a_start_dir: assert property (
		take && homing_mode == `AHS_MODE_19 && !home_sw |=> move_dir_pos && !move_speed_hi)
		else $error("wrong start motion");
	a_latch_off: assert property (
		busy && (mode_reg == `AHS_MODE_19 || mode_reg == `AHS_MODE_21) && $fell(home_sw)
		|=> done) else $error("no latch at home off");
	a_latch_on: assert property (
		busy && (mode_reg == `AHS_MODE_20 || mode_reg == `AHS_MODE_22) && $rose(home_sw)
		|=> done) else $error("no latch at home on");
	a_latch_lim: assert property (
		busy && (mode_reg == `AHS_MODE_17 && $fell(lim_neg)
		|| mode_reg == `AHS_MODE_18 && $fell(lim_pos)) |=> done)
		else $error("no latch at limit off");
	a_z_ignored: assert property (
		busy && mode_reg >= `AHS_MODE_17 && $rose(index_pulse) && $stable(home_sw)
		&& $stable(lim_pos) && $stable(lim_neg) |=> !done) else $error("index used");
	a_stop_out: assert property (
		done |-> home_latch && !busy && !move_en && !move_dir_pos && !move_speed_hi
		##1 !done) else $error("bad stop cycle");
endmodule

bind ahs_sequencer ahs_checker i_chk (
	.clk            (clk),
	.resetn         (resetn),
	.homing_command (homing_command),
	.homing_mode    (homing_mode),
	.home_sw        (home_sw),
	.lim_pos        (lim_pos),
	.lim_neg        (lim_neg),
	.index_pulse    (index_pulse),
	.move_en        (move_en),
	.move_dir_pos   (move_dir_pos),
	.move_speed_hi  (move_speed_hi),
	.busy           (busy),
	.home_latch     (home_latch),
	.done           (done),
	.mode_error     (mode_error)
);

// ---- ahs_axis_model.sv ----
// Purpose: servo axis model with home switch, limits and index
// Assumes: one position step per clock while move_en is high
// Notes:   home on over 100..120, limits at 0 and 200, index every 16
`timescale 1ns/10ps

module ahs_axis_model (
	// clock and preset
	input  wire clk,
	input  wire load,
	input  int  start_pos,
	// motion demand
	input  wire move_en,
	input  wire move_dir_pos,
	// position and sensors
	output int  pos,
	output wire home_sw,
	output wire lim_pos,
	output wire lim_neg,
	output wire index_pulse
);
	always @(posedge clk) begin
		if (load)
			pos <= start_pos;
		else if (move_en)
			pos <= move_dir_pos ? pos + 1 : pos - 1;
	end
	assign home_sw     = pos >= 100 && pos <= 120;
	assign lim_neg     = pos <= 0;
	assign lim_pos     = pos >= 200;
	assign index_pulse = pos[3:0] == 4'h0;
endmodule

// ---- ahs_sequencer_test.sv ----
// Purpose: self-checking bench for ahs_sequencer
// Assumes: axis model moves one step per clock
// Notes:   expected home positions follow from the model geometry
`timescale 1ns/10ps
`include "ahs_consts.vh"
`define CHK(nm, ex, got) \
	begin \
		checks_done = checks_done + 1; \
		if ((got) !== (ex)) begin \
			n_mismatch = n_mismatch + 1; \
			$display("unexpected %s: expected %0d seen %0d", nm, ex, got); \
		end \
	end

module ahs_sequencer_test;
	reg                   clk            = 1'b0;
	reg                   resetn         = 1'b0;
	reg                   homing_command = 1'b0;
	reg [`AHS_MODE_W-1:0] homing_mode    = 5'h00;
	reg                   load           = 1'b0;
	int                   start_pos      = 0;
	int                   n_mismatch     = 0;
	int                   checks_done    = 0;
	int                   pos;
	wire                  home_sw, lim_pos, lim_neg, index_pulse;
	wire                  move_en, move_dir_pos, move_speed_hi;
	wire                  busy, home_latch, done, mode_error;

	always #12.5 clk = ~clk;
	ahs_sequencer i_dut (
		.clk            (clk),
		.resetn         (resetn),
		.homing_command (homing_command),
		.homing_mode    (homing_mode),
		.home_sw        (home_sw),
		.lim_pos        (lim_pos),
		.lim_neg        (lim_neg),
		.index_pulse    (index_pulse),
		.move_en        (move_en),
		.move_dir_pos   (move_dir_pos),
		.move_speed_hi  (move_speed_hi),
		.busy           (busy),
		.home_latch     (home_latch),
		.done           (done),
		.mode_error     (mode_error)
	);
	ahs_axis_model i_axis (
		.clk          (clk),
		.load         (load),
		.start_pos    (start_pos),
		.move_en      (move_en),
		.move_dir_pos (move_dir_pos),
		.pos          (pos),
		.home_sw      (home_sw),
		.lim_pos      (lim_pos),
		.lim_neg      (lim_neg),
		.index_pulse  (index_pulse)
	);

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// one homing run from a preset position
	// sds: expected start motion {dir, speed}
	task automatic run_case(input [`AHS_MODE_W-1:0] m, input int sp, input [1:0] sds,
	                        input int ex);
		int n;
		start_pos = sp;
		load = 1'b1;
		@(negedge clk);
		load = 1'b0;
		homing_mode = m;
		homing_command = 1'b1;
		@(negedge clk);
		homing_command = 1'b0;
		`CHK("start busy", 1'b1, busy)
		`CHK("start motion", sds, {move_dir_pos, move_speed_hi})
		`CHK("no mode error", 1'b0, mode_error)
		n = 0;
		while (done !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n = n + 1;
		end
		if (n >= 1000) begin
			n_mismatch = n_mismatch + 1;
			end_sim;
		end
		`CHK("home position", ex, pos)
		`CHK("home latch", 1'b1, home_latch)
		homing_command = 1'b1;
		@(negedge clk);
		homing_command = 1'b0;
		`CHK("busy after stop cycle", 1'b0, busy)
		@(negedge clk);
	endtask

	task automatic bad_case(input [`AHS_MODE_W-1:0] m);
		reg seen;
		homing_mode = m;
		homing_command = 1'b1;
		@(negedge clk);
		homing_command = 1'b0;
		seen = mode_error;
		@(negedge clk);
		seen = seen | mode_error;
		`CHK("mode error", 1'b1, seen)
		`CHK("busy on bad mode", 1'b0, busy)
	endtask

	// ==========================================================
	// scenarios
	task automatic t_index;
		run_case(`AHS_MODE_12, 150, 2'h0, 111);
		run_case(`AHS_MODE_12, 110, 2'h3, 111);
		run_case(`AHS_MODE_12, 50, 2'h0, 111);
		run_case(`AHS_MODE_13, 150, 2'h0, 113);
		run_case(`AHS_MODE_13, 110, 2'h1, 113);
		run_case(`AHS_MODE_13, 50, 2'h0, 113);
		run_case(`AHS_MODE_14, 150, 2'h0, 95);
		run_case(`AHS_MODE_14, 110, 2'h1, 95);
		run_case(`AHS_MODE_14, 50, 2'h0, 95);
		$display("test index modes ended");
	endtask

	task automatic t_switch;
		run_case(`AHS_MODE_17, 50, 2'h0, 2);
		run_case(`AHS_MODE_17, -5, 2'h3, 2);
		run_case(`AHS_MODE_18, 150, 2'h2, 198);
		run_case(`AHS_MODE_18, 205, 2'h1, 198);
		run_case(`AHS_MODE_19, 50, 2'h2, 98);
		run_case(`AHS_MODE_19, 110, 2'h1, 98);
		run_case(`AHS_MODE_20, 50, 2'h2, 101);
		run_case(`AHS_MODE_20, 110, 2'h1, 101);
		run_case(`AHS_MODE_21, 150, 2'h0, 122);
		run_case(`AHS_MODE_21, 110, 2'h3, 122);
		run_case(`AHS_MODE_22, 110, 2'h3, 119);
		run_case(`AHS_MODE_22, 150, 2'h0, 119);
		$display("test switch modes ended");
	endtask

	task automatic t_reserved;
		bad_case(`AHS_MODE_15);
		bad_case(`AHS_MODE_16);
		bad_case(5'h0b);
		bad_case(5'h17);
		$display("test reserved modes ended");
	endtask

	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		t_index;
		t_switch;
		t_reserved;
		end_sim;
	end
endmodule
